//--- tb_top.sv
// Self-checking bench for the two-wire master receiver against a slave model.
`timescale 1ns/1ns
`include "twm_map.svh"
module tb_top;
    import twm_pkg::*;
    localparam logic [6:0] SADDR = 7'h2A;
    logic mclk_i = 1'b0, arst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0, pull;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, last_rd = 8'h00;
    logic [31:0] seed = 32'hF02E0A78, bytes = 32'h0;
    // Stands in for a second master that holds SDA low and wins arbitration.
    logic jam = 1'b0;
    twm_pins_t pins_o;
    twm_line_t line_i;
    logic [8:0] exp_q[$];
    int mismatches = 0, samples_checked = 0;
    always #5 mclk_i = ~mclk_i;
    // Open-drain wires with pull-ups: whoever pulls low wins.
    assign line_i = {!pins_o.scl_oe, !pins_o.sda_oe && !pull && !jam};
    twm_master_rx #(.QTR_CYC(4)) dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .line_i(line_i),
        .pins_o(pins_o));
    twm_slave_model #(.ADDR(SADDR)) slave (.scl_i(line_i.scl), .sda_i(line_i.sda),
        .bytes_i(bytes), .pull_o(pull));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic results;
        $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic care);
        @(posedge mclk_i);
        addr_i <= a; rd_i <= 1'b1;
        exp_q.push_back({care, e});
        @(posedge mclk_i);
        rd_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
    endtask
    // Polls a register until the masked bits match; a hang counts as a mismatch.
    task automatic await(input logic [1:0] a, input logic [7:0] m, input logic [7:0] v);
        int n;
        n = 0;
        do begin
            rd(a, 8'h00, 1'b0);
            n++;
        end while ((last_rd & m) !== v && n < 400);
        if (n >= 400) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, last_rd & m, v);
        end
    endtask
    task automatic step(input logic [7:0] c, input logic [7:0] st);
        wr(2'h0, c);
        await(2'h0, 8'h80, 8'h80);
        rd(2'h1, st, 1'b1);
    endtask
    always @(posedge mclk_i) begin
        logic [8:0] e;
        if (rd_d) begin
            e = exp_q.pop_front();
            last_rd = rdata_o;
            if (e[8]) cmp8(rdata_o, e[7:0]);
        end
        rd_d <= rd_i;
    end
    initial begin
        #400000;
        mismatches++;
        results;
    end
    initial begin
        repeat (10) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        seed = xs(seed);
        bytes = seed;
        rd(2'h0, `TWM_RST_CTRL, 1'b1);
        rd(2'h1, `TWM_ST_IDLE, 1'b1);
        rd(2'h2, `TWM_RST_DATA, 1'b1);
        rd(2'h3, 8'h00, 1'b1);
        wr(2'h1, 8'hFF);
        rd(2'h1, 8'hFB, 1'b1);
        wr(2'h1, 8'h00);
        step(8'hA4, `TWM_ST_START);
        wr(2'h2, {SADDR, 1'b1});
        step(8'hC4, `TWM_ST_RA_ACK);
        repeat (60) @(posedge mclk_i);
        rd(2'h1, `TWM_ST_RA_ACK, 1'b1);
        step(8'hC4, `TWM_ST_RD_ACK);
        rd(2'h2, bytes[31:24], 1'b1);
        step(8'h84, `TWM_ST_RD_NACK);
        rd(2'h2, bytes[23:16], 1'b1);
        step(8'hA4, `TWM_ST_RSTART);
        wr(2'h2, {~SADDR, 1'b1});
        step(8'h84, `TWM_ST_RA_NACK);
        seed = xs(seed);
        bytes = seed;
        step(8'hB4, `TWM_ST_START);
        wr(2'h2, {SADDR, 1'b1});
        step(8'h84, `TWM_ST_RA_ACK);
        step(8'h84, `TWM_ST_RD_NACK);
        rd(2'h2, bytes[31:24], 1'b1);
        wr(2'h0, 8'h94);
        await(2'h0, 8'h10, 8'h00);
        rd(2'h0, 8'h04, 1'b1);
        rd(2'h1, `TWM_ST_IDLE, 1'b1);
        step(8'hA4, `TWM_ST_START);
        wr(2'h2, {SADDR, 1'b1});
        // The jammed line overrides the first address bit that the master leaves high.
        jam <= 1'b1;
        step(8'h84, `TWM_ST_LOST);
        jam <= 1'b0;
        wr(2'h0, 8'h84);
        rd(2'h1, `TWM_ST_IDLE, 1'b1);
        rd(2'h0, 8'h04, 1'b1);
        results;
    end
endmodule

//--- twm_map.svh
// Register offsets, status codes, reset values and timing constants of the two-wire master.
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH

`define TWM_A_CTRL 2'h0
`define TWM_A_STAT 2'h1
`define TWM_A_DATA 2'h2

`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_WA_ACK 8'h18
`define TWM_ST_WA_NACK 8'h20
`define TWM_ST_TD_ACK 8'h28
`define TWM_ST_TD_NACK 8'h30
`define TWM_ST_LOST 8'h38
`define TWM_ST_RA_ACK 8'h40
`define TWM_ST_RA_NACK 8'h48
`define TWM_ST_RD_ACK 8'h50
`define TWM_ST_RD_NACK 8'h58
`define TWM_ST_IDLE 8'hF8

`define TWM_RST_CTRL 8'h00
`define TWM_RST_DATA 8'hFF
`define TWM_RST_PRESC 2'h0

`define TWM_BIT_ACK 4'h8
`define TWM_PH_LAST 2'h3

`define TWM_CLK_NS 10
`define TWM_QTR_NS 2500

`endif

//--- twm_master_rx.sv
// Two-wire master receiver: register port, bus monitor and bit engine.
//
// Summary of operation
// - Every master transfer begins with a START.
// - Address read bit selects receive, write transmit.
// - START goes out only on a free bus, except a repeated START.
// - After START, flag sets, status 0x08.
// - After address acknowledge, status 0x38/0x40/0x48.
// - Received byte readable while flag is set.
// - Repeated START gives status 0x10, keeps bus.
// - At 0x08/0x10 loaded address byte is sent.
// - 0x38: release bus, or START when free.
// - At 0x40, receive byte, ack per enable.
// - At 0x48: restart, STOP, or STOP then START.
// - At 0x50, receive next byte, ack per enable.
// - At 0x58: restart, STOP, or STOP then START.
// - Hardware clears stop bit after STOP sent.
`timescale 1ns/1ns
`include "twm_map.svh"
module twm_master_rx #(
    parameter int QTR_CYC = (`TWM_QTR_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire twm_pkg::twm_line_t line_i,
    output twm_pkg::twm_pins_t pins_o
);
    import twm_pkg::*;

    twm_line_t line_s, line_d_r, line_d_nxt;
    logic busy_r, busy_nxt, bus_free;
    twm_state_t st_r, st_nxt;
    logic [1:0] ph_r, ph_nxt, presc_r, presc_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] shift_r, shift_nxt, data_r, data_nxt;
    logic [7:0] stat_r, stat_nxt, rdata_r, rdata_nxt;
    twm_ctrl_t ctrl_r, ctrl_nxt, w;
    logic rx_r, rx_nxt, addr_r, addr_nxt, ack_sel_r, ack_sel_nxt;
    logic samp_r, samp_nxt, own_r, own_nxt;
    twm_pins_t pins_r, pins_nxt;
    logic tick, go, drive_bit, restart;

    twm_sync #(.W(2)) u_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .d_i(line_i),
        .q_o(line_s)
    );

    assign restart = st_nxt != st_r;

    twm_tick #(.QTR_CYC(QTR_CYC)) u_tick (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .restart_i(restart),
        .tick_o(tick)
    );

    always_comb begin
        line_d_nxt = line_s;
        busy_nxt = busy_r;
        if (line_s.scl && line_d_r.scl && line_d_r.sda && !line_s.sda) begin
            busy_nxt = 1'b1;
        end else if (line_s.scl && line_d_r.scl && !line_d_r.sda && line_s.sda) begin
            busy_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            line_d_r <= '1;
            busy_r <= 1'b0;
        end else begin
            line_d_r <= line_d_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign bus_free = !busy_r && line_s.scl && line_s.sda;
    // Bits the master itself sends can be overridden by another master where it leaves them high.
    assign drive_bit = (bit_r != `TWM_BIT_ACK) ? (!rx_r || addr_r) : (rx_r && !addr_r);

    always_comb begin
        w = twm_ctrl_t'(wdata_i);
        go = wr_i && addr_i == `TWM_A_CTRL && w.flag;
        ctrl_nxt = ctrl_r;
        stat_nxt = stat_r;
        presc_nxt = presc_r;
        data_nxt = data_r;
        st_nxt = st_r;
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        shift_nxt = shift_r;
        rx_nxt = rx_r;
        addr_nxt = addr_r;
        ack_sel_nxt = ack_sel_r;
        samp_nxt = samp_r;
        own_nxt = own_r;
        pins_nxt = pins_r;
        rdata_nxt = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `TWM_A_CTRL: rdata_nxt = ctrl_r;
                `TWM_A_STAT: rdata_nxt = {stat_r[7:3], 1'b0, presc_r};
                `TWM_A_DATA: rdata_nxt = data_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
        if (wr_i) begin
            case (addr_i)
                `TWM_A_CTRL: begin
                    ctrl_nxt.ack_en = w.ack_en;
                    ctrl_nxt.sta = w.sta;
                    ctrl_nxt.sto = w.sto;
                    ctrl_nxt.en = w.en;
                    ctrl_nxt.ie = w.ie;
                    if (w.flag) begin
                        ctrl_nxt.flag = 1'b0;
                        stat_nxt = `TWM_ST_IDLE;
                    end
                end
                `TWM_A_STAT: presc_nxt = wdata_i[1:0];
                `TWM_A_DATA: begin
                    // A write while the engine owns the data register is refused.
                    if (ctrl_r.flag) begin
                        data_nxt = wdata_i;
                        ctrl_nxt.wcol = 1'b0;
                    end else begin
                        ctrl_nxt.wcol = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (!ctrl_r.en && !(go && w.en)) begin
            st_nxt = S_IDLE;
            own_nxt = 1'b0;
            pins_nxt.scl_oe = 1'b0;
            pins_nxt.sda_oe = 1'b0;
        end else begin
            unique case (st_r)
                S_IDLE: begin
                    if (go && w.sta) begin
                        st_nxt = S_WAIT;
                        own_nxt = 1'b0;
                    end
                end
                S_WAIT: begin
                    if (bus_free) begin
                        st_nxt = S_START;
                        ph_nxt = 2'h0;
                    end
                end
                S_START: begin
                    if (tick) begin
                        ph_nxt = ph_r + 2'h1;
                        case (ph_r)
                            2'h0: pins_nxt.sda_oe = 1'b0;
                            2'h1: pins_nxt.scl_oe = 1'b0;
                            2'h2: pins_nxt.sda_oe = 1'b1;
                            default: begin
                                pins_nxt.scl_oe = 1'b1;
                                ctrl_nxt.flag = 1'b1;
                                stat_nxt = own_r ? `TWM_ST_RSTART : `TWM_ST_START;
                                own_nxt = 1'b1;
                                st_nxt = S_HOLD;
                            end
                        endcase
                    end
                end
                S_HOLD: begin
                    if (go) begin
                        ph_nxt = 2'h0;
                        bit_nxt = 4'h0;
                        case (stat_r)
                            `TWM_ST_START, `TWM_ST_RSTART: begin
                                shift_nxt = data_r;
                                rx_nxt = data_r[0];
                                addr_nxt = 1'b1;
                                st_nxt = S_BIT;
                            end
                            `TWM_ST_RA_ACK, `TWM_ST_RD_ACK: begin
                                rx_nxt = 1'b1;
                                addr_nxt = 1'b0;
                                ack_sel_nxt = w.ack_en;
                                st_nxt = S_BIT;
                            end
                            `TWM_ST_LOST: begin
                                own_nxt = 1'b0;
                                st_nxt = w.sta ? S_WAIT : S_IDLE;
                            end
                            default: begin
                                if (w.sto) begin
                                    st_nxt = S_STOP;
                                end else if (w.sta) begin
                                    st_nxt = S_START;
                                end else if (!rx_r) begin
                                    shift_nxt = data_r;
                                    addr_nxt = 1'b0;
                                    st_nxt = S_BIT;
                                end
                            end
                        endcase
                    end
                end
                S_BIT: begin
                    if (tick) begin
                        ph_nxt = ph_r + 2'h1;
                        case (ph_r)
                            2'h0: begin
                                if (bit_r != `TWM_BIT_ACK) begin
                                    pins_nxt.sda_oe = (rx_r && !addr_r) ? 1'b0 : !shift_r[7];
                                end else begin
                                    pins_nxt.sda_oe = (rx_r && !addr_r) ? ack_sel_r : 1'b0;
                                end
                            end
                            2'h1: pins_nxt.scl_oe = 1'b0;
                            2'h2: begin
                                // A slave may stretch the clock; sample only once SCL is high.
                                if (!line_s.scl) begin
                                    ph_nxt = ph_r;
                                end else if (drive_bit && !pins_r.sda_oe && !line_s.sda) begin
                                    pins_nxt.scl_oe = 1'b0;
                                    pins_nxt.sda_oe = 1'b0;
                                    ctrl_nxt.flag = 1'b1;
                                    stat_nxt = `TWM_ST_LOST;
                                    own_nxt = 1'b0;
                                    st_nxt = S_HOLD;
                                end else if (bit_r != `TWM_BIT_ACK) begin
                                    shift_nxt = {shift_r[6:0], line_s.sda};
                                end else begin
                                    samp_nxt = line_s.sda;
                                end
                            end
                            default: begin
                                pins_nxt.scl_oe = 1'b1;
                                bit_nxt = bit_r + 4'h1;
                                if (bit_r == `TWM_BIT_ACK) begin
                                    ctrl_nxt.flag = 1'b1;
                                    st_nxt = S_HOLD;
                                    if (addr_r && rx_r) begin
                                        stat_nxt = samp_r ? `TWM_ST_RA_NACK : `TWM_ST_RA_ACK;
                                    end else if (addr_r) begin
                                        stat_nxt = samp_r ? `TWM_ST_WA_NACK : `TWM_ST_WA_ACK;
                                    end else if (rx_r) begin
                                        data_nxt = shift_r;
                                        stat_nxt = ack_sel_r ? `TWM_ST_RD_ACK : `TWM_ST_RD_NACK;
                                    end else begin
                                        stat_nxt = samp_r ? `TWM_ST_TD_NACK : `TWM_ST_TD_ACK;
                                    end
                                end
                            end
                        endcase
                    end
                end
                S_STOP: begin
                    if (tick) begin
                        ph_nxt = ph_r + 2'h1;
                        case (ph_r)
                            2'h0: pins_nxt.sda_oe = 1'b1;
                            2'h1: pins_nxt.scl_oe = 1'b0;
                            2'h2: pins_nxt.sda_oe = 1'b0;
                            default: begin
                                ctrl_nxt.sto = 1'b0;
                                own_nxt = 1'b0;
                                stat_nxt = `TWM_ST_IDLE;
                                st_nxt = ctrl_r.sta ? S_WAIT : S_IDLE;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_r <= twm_ctrl_t'(`TWM_RST_CTRL);
            stat_r <= `TWM_ST_IDLE;
            presc_r <= `TWM_RST_PRESC;
            data_r <= `TWM_RST_DATA;
            st_r <= S_IDLE;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            rx_r <= 1'b0;
            addr_r <= 1'b0;
            ack_sel_r <= 1'b0;
            samp_r <= 1'b1;
            own_r <= 1'b0;
            pins_r <= '0;
            rdata_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            presc_r <= presc_nxt;
            data_r <= data_nxt;
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            bit_r <= bit_nxt;
            shift_r <= shift_nxt;
            rx_r <= rx_nxt;
            addr_r <= addr_nxt;
            ack_sel_r <= ack_sel_nxt;
            samp_r <= samp_nxt;
            own_r <= own_nxt;
            pins_r <= pins_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign pins_o = pins_r;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    property p_start_done;
        (st_r == S_START && tick && ph_r == `TWM_PH_LAST && ctrl_r.en) |=> (ctrl_r.flag &&
            (stat_r == `TWM_ST_START || stat_r == `TWM_ST_RSTART));
    endproperty
    a_start_done: assert property (p_start_done) else $error("start without flag");

    property p_wait_free;
        (st_r == S_WAIT && !bus_free && ctrl_r.en) |=> st_r == S_WAIT;
    endproperty
    a_wait_free: assert property (p_wait_free) else $error("start on busy bus");

    property p_addr_status;
        (st_r == S_BIT && tick && ph_r == `TWM_PH_LAST && bit_r == `TWM_BIT_ACK && addr_r && rx_r
            && ctrl_r.en) |=> ctrl_r.flag && stat_r inside {`TWM_ST_RA_ACK, `TWM_ST_RA_NACK};
    endproperty
    a_addr_status: assert property (p_addr_status) else $error("bad address status");

    property p_lost;
        (st_r == S_BIT && tick && ph_r == 2'h2 && drive_bit && !pins_r.sda_oe && line_s.scl
            && !line_s.sda && ctrl_r.en) |=> stat_r == `TWM_ST_LOST && ctrl_r.flag
            && !pins_r.scl_oe && !pins_r.sda_oe;
    endproperty
    a_lost: assert property (p_lost) else $error("lost arbitration not reported");

    property p_mode;
        (st_r == S_HOLD && go && ctrl_r.en && stat_r inside {`TWM_ST_START, `TWM_ST_RSTART})
            |=> st_r == S_BIT && addr_r && rx_r == $past(data_r[0]);
    endproperty
    a_mode: assert property (p_mode) else $error("direction not taken from address");

    property p_ack_drive;
        (st_r == S_BIT && bit_r == `TWM_BIT_ACK && rx_r && !addr_r && ph_r == 2'h2)
            |-> pins_r.sda_oe == ack_sel_r;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("wrong ack level");

    property p_rx_byte;
        (st_r == S_BIT && tick && ph_r == `TWM_PH_LAST && bit_r == `TWM_BIT_ACK && rx_r && !addr_r
            && ctrl_r.en) |=> ctrl_r.flag && data_r == $past(shift_r) &&
            stat_r == ($past(ack_sel_r) ? `TWM_ST_RD_ACK : `TWM_ST_RD_NACK);
    endproperty
    a_rx_byte: assert property (p_rx_byte) else $error("received byte or status wrong");

    property p_flag_quiet;
        (ctrl_r.flag && ctrl_r.en) |=> $stable(pins_r);
    endproperty
    a_flag_quiet: assert property (p_flag_quiet) else $error("bus moved while flag set");

    property p_stop_clear;
        (st_r == S_STOP && tick && ph_r == `TWM_PH_LAST && ctrl_r.en)
            |=> !ctrl_r.sto && st_r inside {S_WAIT, S_IDLE};
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop bit not cleared");

    property p_nack_route;
        (st_r == S_HOLD && go && ctrl_r.en && w.sto
            && stat_r inside {`TWM_ST_RA_NACK, `TWM_ST_RD_NACK}) |=> st_r == S_STOP;
    endproperty
    a_nack_route: assert property (p_nack_route) else $error("stop not issued");

    c_rd_ack: cover property (ctrl_r.flag && stat_r == `TWM_ST_RD_ACK);
    c_rd_nack: cover property (ctrl_r.flag && stat_r == `TWM_ST_RD_NACK);
    c_lost: cover property (ctrl_r.flag && stat_r == `TWM_ST_LOST);
    c_rstart: cover property (ctrl_r.flag && stat_r == `TWM_ST_RSTART);
endmodule

//--- twm_pkg.sv
// Types shared by the two-wire master receiver files.
package twm_pkg;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_WAIT = 6'h02,
        S_START = 6'h04,
        S_BIT = 6'h08,
        S_STOP = 6'h10,
        S_HOLD = 6'h20
    } twm_state_t;

    typedef struct packed {
        logic flag;
        logic ack_en;
        logic sta;
        logic sto;
        logic wcol;
        logic en;
        logic rsv;
        logic ie;
    } twm_ctrl_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } twm_line_t;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } twm_pins_t;

endpackage

//--- twm_slave_model.sv
// Slave transmitter model that answers read transfers on the open-drain bus.
`timescale 1ns/1ns
module twm_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [31:0] bytes_i,
    output logic pull_o
);
    logic act, dat, mnack;
    logic [3:0] cnt;
    logic [7:0] sh, tx;
    logic [1:0] idx;
    initial begin
        act = 1'b0; dat = 1'b0; mnack = 1'b0; pull_o = 1'b0;
        cnt = 4'h0; sh = 8'h00; tx = 8'h00; idx = 2'h0;
    end
    always @(negedge sda_i) begin
        if (scl_i) begin
            act = 1'b1; dat = 1'b0; cnt = 4'hF; pull_o = 1'b0;
        end
    end
    always @(posedge sda_i) begin
        if (scl_i) begin
            act = 1'b0; pull_o = 1'b0;
        end
    end
    always @(posedge scl_i) begin
        if (act && !dat && cnt < 4'h8) sh = {sh[6:0], sda_i};
        if (act && dat && cnt == 4'h8) mnack = sda_i;
    end
    always @(negedge scl_i) begin
        if (act) begin
            if (cnt == 4'h8) begin
                cnt = 4'h0;
                if ((!dat && sh == {ADDR, 1'b1}) || (dat && !mnack)) begin
                    if (!dat) idx = 2'h0;
                    dat = 1'b1;
                    tx = bytes_i[8*(3-idx) +: 8];
                    idx = idx + 2'h1;
                    pull_o = !tx[7];
                end else begin
                    act = 1'b0; pull_o = 1'b0;
                end
            end else begin
                cnt = cnt + 4'h1;
                if (cnt == 4'h8) pull_o = dat ? 1'b0 : (sh == {ADDR, 1'b1});
                else if (dat) pull_o = !tx[4'h7 - cnt];
            end
        end
    end
endmodule

//--- twm_sync.sv
// Two-flop synchroniser for the sampled bus lines.
`timescale 1ns/1ns
module twm_sync #(
    parameter int W = 2
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // Resets to ones because an idle open-drain bus reads high.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= '1;
            q_r <= '1;
        end else begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end

    assign q_o = q_r;
endmodule

//--- twm_tick.sv
// Quarter-bit tick generator that paces every bus phase.
`timescale 1ns/1ns
`include "twm_map.svh"
module twm_tick #(
    parameter int QTR_CYC = (`TWM_QTR_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic restart_i,
    output logic tick_o
);
    localparam int CW = $clog2(QTR_CYC + 1);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic tick_r, tick_nxt;

    // Restart realigns the phase grid whenever the engine changes state.
    always_comb begin
        cnt_nxt = cnt_r + 1'b1;
        tick_nxt = 1'b0;
        if (restart_i) begin
            cnt_nxt = '0;
        end else if (cnt_r == CW'(QTR_CYC - 1)) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;
endmodule
